// *** dv/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import adcs_pkg::*;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, pin, tmr, clr;
  logic awready, wready, bvalid, arready, rvalid, irq, dma_all;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, rng;
  logic [7:0] dma, dma_or;
  logic [13:0] cdata;
  logic [1:0] cfg_ref;
  adcs_cfg_t cfg;
  logic busy;
  int n_all, n_irq, bcnt, last_len, n_tests, fail_count;

  // Conversions are shortened to one clock per quarter microsecond.
  adcs_seq_ctrl #(.CONV_TICK(1)) DUT (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_trigger_pin(pin), .timer_compare_event(tmr), .conv_data(cdata), .conv_cfg(cfg),
    .conv_busy(busy), .rng_control(rng), .single_done_irq(irq), .dma_request(dma),
    .dma_request_all(dma_all));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Event monitor; counters are cleared by the scenario through clr so no race arises.
  always @(posedge clock)
  begin
    if (clr)
    begin
      n_all <= 0;
      n_irq <= 0;
      dma_or <= 8'h00;
      bcnt <= 0;
    end
    else
    begin
      n_all <= n_all + int'(dma_all);
      n_irq <= n_irq + int'(irq);
      dma_or <= dma_or | dma;
      if (busy)
      begin
        bcnt <= bcnt + 1;
        cfg_ref <= cfg.reference;
      end
      else if (bcnt != 0)
      begin
        last_len <= bcnt;
        bcnt <= 0;
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, where the values going into the next rising edge are settled.
  task automatic axw(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic aw_ok, w_ok, b_ok, fin;
    fin = 1'b0;
    @(posedge clock);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin)
    begin
      @(negedge clock);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      resp = bresp;
      @(posedge clock);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
      fin = b_ok;
    end
  endtask

  task automatic axr(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] resp);
    logic ar_ok, r_ok, fin;
    fin = 1'b0;
    @(posedge clock);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin)
    begin
      @(negedge clock);
      ar_ok = arvalid && arready;
      r_ok = rvalid && rready;
      d = rdata[7:0];
      resp = rresp;
      @(posedge clock);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
      fin = r_ok;
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axw(idx, d, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic [1:0] r;
    axr(idx, d, r);
    chk(r, RESP_OKAY);
  endtask

  task automatic clr_mon();
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask

  // Waits for a conversion to begin, then for the converter to stay idle for three cycles.
  task automatic wait_idle();
    int s;
    s = 0;
    do @(negedge clock); while (!busy);
    while (s < 3)
    begin
      @(negedge clock);
      s = busy ? 0 : s + 1;
    end
  endtask

  task automatic t_reset();
    logic [7:0] v;
    logic [1:0] r;
    rd(IDX_CTRL1, v);
    chk(v, 8'h33);
    chk(rng, 2'h0);
    rd(IDX_SEQ, v);
    chk(v, 8'h10);
    rd(IDX_HIGH, v);
    chk(v, 8'h00);
    axr(8'h00, v, r);
    chk({v, r}, {8'h00, RESP_SLVERR});
    axw(8'h00, 8'hFF, r);
    chk(r, RESP_SLVERR);
    wr(IDX_HIGH, 8'h55);
    rd(IDX_HIGH, v);
    chk(v, 8'h00);
  endtask

  // Start bit with the pin selected as source must be ignored.
  task automatic t_refuse();
    logic [7:0] v;
    wr(IDX_CTRL1, 8'h4B);
    rd(IDX_CTRL1, v);
    chk(v, 8'h0B);
    chk(rng, 2'h2);
    repeat (20) @(posedge clock);
    chk(busy, 1'b0);
  endtask

  task automatic run_seq(input logic [7:0] sv, input logic [1:0] src, input int n, input logic [7:0] mask,
                         input logic [3:0] rb);
    logic [7:0] v;
    wr(IDX_SEQ, sv);
    clr_mon();
    wr(IDX_CTRL1, {1'b0, src == SRC_BIT, src, 4'h3});
    if (src == SRC_BIT)
    begin
      rd(IDX_CTRL1, v);
      chk(v[ST_BIT], 1'b1);
    end
    if (src == SRC_PIN)
    begin
      @(posedge clock);
      pin <= 1'b1;
      repeat (4) @(posedge clock);
      pin <= 1'b0;
    end
    if (src == SRC_TIMER)
    begin
      @(posedge clock);
      tmr <= 1'b1;
      @(posedge clock);
      tmr <= 1'b0;
    end
    wait_idle();
    rd(IDX_CTRL1, v);
    chk(v, {2'b10, src, 4'h3});
    rd(IDX_SEQ, v);
    chk(v, {sv[7:4], rb});
    chk(n_all, n);
    chk(dma_or, mask);
    chk(n_irq, 0);
    chk(cfg_ref, sv[7:6]);
    chk(last_len, DECIM_BASE + DECIM_EXTRA);
    rd(IDX_LOW, v);
    chk(v, {cdata[5:0], 2'b00});
    rd(IDX_HIGH, v);
    chk(v, cdata[13:6]);
    rd(IDX_CTRL1, v);
    chk(v[EOC_BIT], 1'b0);
  endtask

  task automatic t_full();
    logic [7:0] v;
    wr(IDX_SEQ, 8'h00);
    clr_mon();
    wr(IDX_CTRL1, 8'h13);
    repeat (300) @(posedge clock);
    chk(n_all >= 3, 1'b1);
    wr(IDX_CTRL1, 8'h33);
    // The running conversion may already be over, so wait a fixed span longer than one conversion.
    repeat (200) @(posedge clock);
    chk(busy, 1'b0);
    rd(IDX_HIGH, v);
  endtask

  task automatic t_single();
    logic [7:0] v;
    clr_mon();
    wr(IDX_SINGLE, 8'h35);
    wait_idle();
    chk(n_irq, 1);
    chk(n_all, 0);
    chk(last_len, (DECIM_BASE << 3) + DECIM_EXTRA);
    rd(IDX_CTRL1, v);
    chk(v[EOC_BIT], 1'b1);
  endtask

  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, pin, tmr, clr} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    cdata = 14'h2ABD;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_refuse();
    run_seq(8'h02, SRC_BIT, 3, 8'h07, 4'h3);
    run_seq(8'h49, SRC_BIT, 2, 8'h03, 4'hA);
    run_seq(8'h8C, SRC_PIN, 1, 8'h00, 4'hC);
    run_seq(8'hC7, SRC_TIMER, 8, 8'hFF, 4'h8);
    t_full();
    t_single();
    summarize();
  end

  // Whole run needs about 2500 cycles; this span leaves ample margin.
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire

// *** verilog/adcs_conv_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module adcs_conv_timer #(
  parameter int unsigned TICK = 25
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [1:0] decimation,
  input wire logic [adcs_pkg::RES_W-1:0] conv_data,
  output logic busy,
  output logic done,
  output logic [adcs_pkg::RES_W-1:0] result
);
  import adcs_pkg::*;

  logic [1:0] decim_q;
  logic [15:0] tick_cnt;
  logic [9:0] quarter_cnt;
  logic [9:0] quarters;
  logic tick_end;
  logic [23:0] len_cnt;

  // Length in quarter microseconds: decimation rate plus sixteen.
  assign quarters = 10'(DECIM_BASE << decim_q) + 10'(DECIM_EXTRA);
  assign tick_end = (tick_cnt == 16'(TICK - 1));

  // The core's data is sampled only on the last tick, so it may settle late.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      decim_q <= 2'h0;
      tick_cnt <= 16'h0000;
      quarter_cnt <= 10'h000;
      result <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        decim_q <= decimation;
        tick_cnt <= 16'h0000;
        quarter_cnt <= 10'h000;
      end
      else if (busy)
      begin
        tick_cnt <= tick_end ? 16'h0000 : tick_cnt + 16'h0001;
        if (tick_end && quarter_cnt == quarters - 10'h001)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= conv_data;
        end
        else if (tick_end)
        begin
          quarter_cnt <= quarter_cnt + 10'h001;
        end
      end
    end
  end

  // Helper that measures each conversion for the length check.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      len_cnt <= 24'h000000;
    else
      len_cnt <= busy ? len_cnt + 24'h000001 : 24'h000000;
  end

  conv_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(busy) |-> $past(len_cnt) == 24'(quarters * TICK) - 24'h000001)
    else $error("Conversion length does not match decimation rate.");
endmodule
`default_nettype wire

// *** verilog/adcs_pkg.sv ***
package adcs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_PS = 250000;
  localparam int TICK_CYC = TICK_TIME_PS / (CLK_PERIOD_NS * 1000);
  localparam int DECIM_BASE = 64;
  localparam int DECIM_EXTRA = 16;
  localparam int RES_W = 14;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL1 = 8'hB4;
  localparam logic [7:0] IDX_LOW = 8'hBA;
  localparam logic [7:0] IDX_HIGH = 8'hBB;
  localparam logic [7:0] IDX_SEQ = 8'hBC;
  localparam logic [7:0] IDX_SINGLE = 8'hBD;
  localparam int EOC_BIT = 7;
  localparam int ST_BIT = 6;
  localparam int START_SOURCE_SELECT_LSB = 4;
  localparam int RNG_LSB = 2;
  localparam int LOW_RES_LSB = 2;
  localparam logic [1:0] START_SOURCE_SELECT_RESET = 2'h3;
  localparam logic [1:0] RNG_RESET = 2'h0;
  localparam logic [1:0] CTRL1_LOW_RESET = 2'h3;
  localparam logic [1:0] REF_RESET = 2'h0;
  localparam logic [1:0] DECIM_RESET = 2'h1;
  localparam logic [3:0] CH_RESET = 4'h0;
  localparam logic [3:0] CH_LAST_SINGLE = 4'h7;
  localparam logic [3:0] CH_FIRST_DIFF = 4'h8;
  localparam logic [3:0] CH_LAST_DIFF = 4'hB;
  localparam int DMA_CH = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_FULL = 2'b01,
    SRC_TIMER = 2'b10,
    SRC_BIT = 2'b11
  } adcs_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEQ = 2'b01,
    ST_SINGLE = 2'b10
  } adcs_state_t;

  // Same layout as the sequence and single-conversion registers.
  typedef struct packed {
    logic [1:0] reference;
    logic [1:0] decimation;
    logic [3:0] channel;
  } adcs_cfg_t;
endpackage

// *** verilog/adcs_seq_ctrl.sv ***
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module adcs_seq_ctrl #(
  parameter int unsigned CONV_TICK = adcs_pkg::TICK_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [adcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_trigger_pin,
  input wire logic timer_compare_event,
  input wire logic [adcs_pkg::RES_W-1:0] conv_data,
  output adcs_pkg::adcs_cfg_t conv_cfg,
  output logic conv_busy,
  output logic [1:0] rng_control,
  output logic single_done_irq,
  output logic [adcs_pkg::DMA_CH-1:0] dma_request,
  output logic dma_request_all
);
  import adcs_pkg::*;

  logic [ADDR_W-1:0] aw_addr;
  logic aw_held, w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic eoc, st, single_pend;
  logic [1:0] start_source_select, rng, ctrl_low, seq_ref, seq_decim;
  logic [3:0] seq_end, seq_ch;
  adcs_cfg_t single_cfg;
  adcs_state_t state;
  logic pin_meta, pin_sync, pin_last;
  logic timer_done;
  logic [RES_W-1:0] result;

  // Write path: address and data are taken in either order, then answered.
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire [7:0] w_idx = aw_addr[ADDR_W-1:2];
  wire wr_ctrl1 = wr_fire && w_lane0 && w_idx == IDX_CTRL1;
  wire wr_seq = wr_fire && w_lane0 && w_idx == IDX_SEQ;
  wire wr_single = wr_fire && w_lane0 && w_idx == IDX_SINGLE;
  wire wr_known = w_idx == IDX_CTRL1 || w_idx == IDX_LOW || w_idx == IDX_HIGH
    || w_idx == IDX_SEQ || w_idx == IDX_SINGLE;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Read path decode.
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire [7:0] r_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_high = rd_fire && r_idx == IDX_HIGH;
  assign s_axi_arready = !s_axi_rvalid;

  // Register images as software sees them.
  wire [7:0] low_byte = {result[5:0], 2'b00};
  wire [7:0] high_byte = result[RES_W-1:6];
  wire [7:0] ctrl1_byte = {eoc, st, start_source_select, rng, ctrl_low};
  wire [7:0] seq_byte = {seq_ref, seq_decim, seq_ch};
  wire r_known = r_idx == IDX_CTRL1 || r_idx == IDX_LOW || r_idx == IDX_HIGH
    || r_idx == IDX_SEQ || r_idx == IDX_SINGLE;
  wire [7:0] rd_byte = r_idx == IDX_CTRL1 ? ctrl1_byte :
    r_idx == IDX_LOW ? low_byte :
    r_idx == IDX_HIGH ? high_byte :
    r_idx == IDX_SEQ ? seq_byte :
    r_idx == IDX_SINGLE ? single_cfg : 8'h00;

  // Start selection; pin and timer events arriving while busy are dropped.
  wire pin_rise = pin_sync && !pin_last;
  wire is_idle = state == ST_IDLE;
  wire seq_trigger = start_source_select == SRC_PIN ? pin_rise :
    start_source_select == SRC_FULL ? 1'b1 :
    start_source_select == SRC_TIMER ? timer_compare_event : st;
  wire start_single = is_idle && single_pend;
  wire start_seq = is_idle && !single_pend && seq_trigger;
  wire seq_last = conv_cfg.channel == seq_end;
  wire seq_step = state == ST_SEQ && timer_done;
  wire chain = seq_step && !seq_last;
  wire conv_start = start_single || start_seq || chain;
  // The source is judged on the value being written, so one write may select 11 and start.
  wire st_launch = wr_ctrl1 && w_byte[ST_BIT] && state != ST_SEQ
    && w_byte[START_SOURCE_SELECT_LSB+1:START_SOURCE_SELECT_LSB] == SRC_BIT;

  // First channel of a sequence depends on where the sequence ends.
  wire [3:0] first_ch = seq_end <= CH_LAST_SINGLE ? 4'h0 :
    seq_end <= CH_LAST_DIFF ? CH_FIRST_DIFF : seq_end;
  wire [3:0] end_ch = seq_end > CH_LAST_DIFF ? seq_end : seq_end + 4'h1;
  wire adcs_cfg_t next_cfg = start_single ? single_cfg :
    start_seq ? {seq_ref, seq_decim, first_ch} :
    {seq_ref, seq_decim, conv_cfg.channel + 4'h1};

  // The pin comes from outside, so it passes two flip-flops before use.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      {pin_meta, pin_sync, pin_last} <= 3'h0;
    else
      {pin_meta, pin_sync, pin_last} <= {external_trigger_pin, pin_meta, pin_sync};
  end

  // Bus handshake state.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= r_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Software-written fields. Bits 1:0 of the first control register are
  // stored as written; software is expected to keep them at 11.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_source_select <= START_SOURCE_SELECT_RESET;
      rng <= RNG_RESET;
      ctrl_low <= CTRL1_LOW_RESET;
      seq_ref <= REF_RESET;
      seq_decim <= DECIM_RESET;
      seq_end <= CH_RESET;
      single_cfg <= '0;
    end
    else
    begin
      if (wr_ctrl1)
      begin
        start_source_select <= w_byte[START_SOURCE_SELECT_LSB+1:START_SOURCE_SELECT_LSB];
        rng <= w_byte[RNG_LSB+1:RNG_LSB];
        ctrl_low <= w_byte[1:0];
      end
      if (wr_seq)
      begin
        {seq_ref, seq_decim, seq_end} <= w_byte;
      end
      if (wr_single)
        single_cfg <= w_byte;
    end
  end

  // Sequencer. A pending single conversion wins over a new sequence when idle.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      seq_ch <= CH_RESET;
      conv_cfg <= '0;
      single_pend <= 1'b0;
      st <= 1'b0;
    end
    else
    begin
      single_pend <= wr_single || (single_pend && !start_single);
      if (conv_start)
        conv_cfg <= next_cfg;
      case (state)
        ST_IDLE:
        begin
          if (start_single)
            state <= ST_SINGLE;
          else if (start_seq)
          begin
            state <= ST_SEQ;
            seq_ch <= first_ch;
          end
          else if (wr_seq)
            seq_ch <= w_byte[3:0];
        end
        ST_SEQ:
        begin
          if (chain)
            seq_ch <= conv_cfg.channel + 4'h1;
          else if (seq_step)
          begin
            state <= ST_IDLE;
            seq_ch <= end_ch;
          end
        end
        ST_SINGLE:
        begin
          if (timer_done)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
      if (st_launch)
        st <= 1'b1;
      else if (seq_step && seq_last)
        st <= 1'b0;
    end
  end

  // Completion flag: a new completion wins over the clearing read.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      eoc <= 1'b0;
    else
      eoc <= timer_done || (eoc && !rd_high);
  end

  // Event outputs: interrupt for single, DMA for sequence conversions.
  // Differential pairs share the trigger of their pair index.
  wire seq_pulse = timer_done && state == ST_SEQ;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      single_done_irq <= 1'b0;
      dma_request_all <= 1'b0;
    end
    else
    begin
      single_done_irq <= timer_done && state == ST_SINGLE;
      dma_request_all <= seq_pulse;
    end
  end

  // One registered trigger per channel slot.
  genvar gi;
  generate
    for (gi = 0; gi < DMA_CH; gi++)
    begin : g_dma
      // Pairs map to slots 0 to 3 only; channels from 12 up have no slot of their own.
      wire [3:0] slot = conv_cfg.channel <= CH_LAST_SINGLE ? conv_cfg.channel :
        conv_cfg.channel - CH_FIRST_DIFF;
      wire hit = conv_cfg.channel <= CH_LAST_DIFF && slot == 4'(gi);
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          dma_request[gi] <= 1'b0;
        else
          dma_request[gi] <= seq_pulse && hit;
      end
    end
  endgenerate

  assign rng_control = rng;

  adcs_conv_timer #(
    .TICK(CONV_TICK)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(conv_start),
    .decimation(next_cfg.decimation),
    .conv_data(conv_data),
    .busy(conv_busy),
    .done(timer_done),
    .result(result)
  );

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  eoc_set_a: assert property (timer_done |=> eoc)
    else $error("Done flag not set after conversion.");
  eoc_keep_a: assert property (eoc && !rd_high |=> eoc)
    else $error("Done flag dropped without read.");
  eoc_clear_a: assert property (rd_high && !timer_done |=> !eoc)
    else $error("Done flag not cleared by high byte read.");
  low_byte_a: assert property (rd_fire && r_idx == IDX_LOW
    |=> s_axi_rdata[7:0] == {$past(result[5:0]), 2'b00})
    else $error("Low byte layout wrong.");
  high_byte_a: assert property (rd_high |=> s_axi_rdata[7:0] == $past(result[13:6]))
    else $error("High byte layout wrong.");
  st_launch_a: assert property (st && is_idle && !single_pend |=> state == ST_SEQ ##0 st)
    else $error("Start bit did not launch sequence.");
  st_hold_a: assert property (st && state == ST_SEQ && !(seq_step && seq_last) |=> st)
    else $error("Start bit fell during sequence.");
  full_speed_a: assert property (start_source_select == SRC_FULL && is_idle && !single_pend
    |=> state == ST_SEQ)
    else $error("Full speed mode did not restart.");
  seq_first_a: assert property (start_seq |=> conv_cfg.channel == $past(first_ch))
    else $error("Sequence began on wrong channel.");
  one_shot_a: assert property (start_seq && seq_end > CH_LAST_DIFF
    |=> conv_cfg.channel == seq_end && seq_last)
    else $error("High channel ran more than one conversion.");
  ch_read_a: assert property (state == ST_SEQ |-> seq_ch == conv_cfg.channel)
    else $error("Channel readback not current channel.");
  irq_single_a: assert property (timer_done && state != ST_SINGLE |=> !single_done_irq)
    else $error("Interrupt from sequence conversion.");
  dma_single_a: assert property (timer_done && state == ST_SINGLE
    |=> !dma_request_all && dma_request == '0)
    else $error("DMA request from single conversion.");
  single_go_a: assert property (single_pend && is_idle |=> state == ST_SINGLE ##[1:2] conv_busy)
    else $error("Pending single conversion did not start.");

  seq_run_c: cover property (seq_step && seq_last ##1 is_idle);
  single_c: cover property (single_done_irq);
  pend_c: cover property (wr_single && state == ST_SEQ);
  eoc_race_c: cover property (timer_done && rd_high);
endmodule
`default_nettype wire
